// file: src/pcv_pkg.sv
package pcv_pkg;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_VDO = 8'h04;
	localparam logic [7:0] OFS_HDR = 8'h08;
	localparam logic [7:0] OFS_CERT = 8'h0C;
	localparam logic [7:0] OFS_PROD = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;

	// ****************************************
	// cable object field positions and widths
	// ****************************************
	localparam int HW_LSB = 28;
	localparam int HW_W = 4;
	localparam int FW_LSB = 24;
	localparam int FW_W = 4;
	localparam int VER_LSB = 21;
	localparam int VER_W = 3;
	localparam int PLUG_LSB = 18;
	localparam int PLUG_W = 2;
	localparam int LAT_LSB = 13;
	localparam int LAT_W = 4;
	localparam int TERM_LSB = 11;
	localparam int TERM_W = 2;
	localparam int VMAX_LSB = 9;
	localparam int VMAX_W = 2;
	localparam int CUR_LSB = 5;
	localparam int CUR_W = 2;
	localparam int VTHRU_BIT = 4;
	localparam int SS_LSB = 0;
	localparam int SS_W = 3;

	// ****************************************
	// legal encodings
	// ****************************************
	localparam logic [2:0] VER_1_0 = 3'h0;
	localparam logic [1:0] PLUG_TYPEC = 2'h2;
	localparam logic [1:0] PLUG_CAPTIVE = 2'h3;
	localparam logic [3:0] LAT_MIN = 4'h1;
	localparam logic [3:0] LAT_MAX = 4'hA;
	localparam logic [1:0] TERM_NONE = 2'h0;
	localparam logic [1:0] TERM_VCONN = 2'h1;
	localparam logic [1:0] CUR_3A = 2'h1;
	localparam logic [1:0] CUR_5A = 2'h2;
	localparam logic [2:0] SS_MAX = 3'h3;

	// ****************************************
	// reset values and status bits
	// ****************************************
	// type-c plug, latency 0001b, 3 A, usb 2.0 only
	localparam logic [31:0] CFG_RST = 32'h0008_2020;
	// identity words: arbitrary neutral values
	localparam logic [31:0] HDR_RST = 32'h0000_0000;
	localparam logic [31:0] CERT_RST = 32'h0000_0000;
	localparam logic [31:0] PROD_RST = 32'h0000_0000;
	localparam int STAT_REJ = 0;
	localparam int STAT_BUSY = 1;
	localparam logic [1:0] ACK_LAST_IDX = 2'h3;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// file: src/pcv_top.sv
// Contract
// - hardware revision in bits 31:28, firmware revision in bits 27:24.
// - object version reads 000b; codes 001b to 111b never emitted.
// - bits 20, 17, 8:7 and 3 are always zero.
// - plug type 10 for type-c, 11 for captive; 00, 01 never emitted.
// - latency 0001b to 1010b only; 0000b and 1011b up never emitted.
// - termination 00b or 01b only; identity-only markers report 00b.
// - voltage field 00b..11b selects 20, 30, 40, 50 V.
// - current 01b is 3 A, 10b is 5 A; 00b, 11b never emitted.
// - superspeed 000b..011b only; 100b to 111b never emitted.
// - answer carries header, certification, product, then cable object.
module pcv_top
	import pcv_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave request
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	// ahb-lite slave answer
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// identity answer request
	input wire logic ack_req,
	// identity answer word stream
	output logic ack_valid,
	output logic [31:0] ack_word,
	output logic ack_last,
	// current cable object
	output logic [31:0] cable_vdo
);

	// ****************************************
	// declarations
	// ****************************************
	// register map, byte offsets decoded from haddr[7:0]:
	//   cfg   settings in the cable object layout, read and write
	//   vdo   packed cable object, read only
	//   hdr, cert, prod   identity words sent ahead of the object
	//   stat  bit 0 refusal, write one to clear; bit 1 answer busy
	// other offsets read zero and ignore writes
	typedef enum logic [0:0] {
		PCV_IDLE = 1'b0,
		PCV_SEND = 1'b1
	} pcv_state_t;

	pcv_state_t state_r;
	pcv_state_t state_nxt;
	logic [1:0] idx_r;
	logic [1:0] idx_nxt;
	logic [31:0] cfg_r;
	logic [31:0] hdr_r;
	logic [31:0] cert_r;
	logic [31:0] prod_r;
	logic [31:0] vdo_r;
	logic rej_r;
	logic rej_nxt;
	logic dp_wr_r;
	logic dp_rd_r;
	logic [7:0] dp_addr_r;
	logic [31:0] hrdata_r;
	logic hreadyout_r;
	logic ack_valid_r;
	logic ack_last_r;
	logic [31:0] ack_word_r;
	logic ap_take;
	logic [31:0] vdo_pack;
	logic [31:0] wr_pack;
	logic wr_legal;
	logic cfg_wr;
	logic stat_wr;
	logic [31:0] rd_mux;
	logic [31:0] word_sel;
	logic hresp_r;

	// ****************************************
	// object packing
	// ****************************************
	// two packers: one shows the stored object, the other judges a write
	// in its data phase so an illegal word never touches the settings;
	// the cost is a second copy of the small field logic
	// packing of the stored settings
	pcv_vdo_pack u_pack_cfg (
		.cfg(cfg_r),
		.vdo(vdo_pack),
		.legal()
	);

	// legality of an incoming settings write
	pcv_vdo_pack u_pack_wr (
		.cfg(hwdata),
		.vdo(wr_pack),
		.legal(wr_legal)
	);

	// registered one edge behind the settings, so cable_vdo never
	// shows a half-built word while the packer settles
	// object follows stored settings
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vdo_r <= CFG_RST;
		end else begin
			vdo_r <= vdo_pack;
		end
	end

	// ****************************************
	// bus address phase
	// ****************************************
	// hsize is not decoded: every register is one whole aligned word,
	// so narrow writes are not supported
	// only nonseq/seq transfers are taken; idle and busy ignored
	assign ap_take = hsel && hready && htrans[1];

	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_r <= 1'b0;
			dp_rd_r <= 1'b0;
			dp_addr_r <= OFS_CFG;
		end else begin
			dp_wr_r <= ap_take && hwrite;
			dp_rd_r <= ap_take && !hwrite;
			if (ap_take) begin
				dp_addr_r <= haddr[7:0];
			end
		end
	end

	// ****************************************
	// register writes
	// ****************************************
	assign cfg_wr = dp_wr_r && (dp_addr_r == OFS_CFG);
	assign stat_wr = dp_wr_r && (dp_addr_r == OFS_STAT);

	// settings change only on a legal write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_r <= CFG_RST;
		end else if (cfg_wr && wr_legal) begin
			// store the packed form so reserved bits read zero
			cfg_r <= wr_pack;
		end
	end

	// identity words written whole
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hdr_r <= HDR_RST;
			cert_r <= CERT_RST;
			prod_r <= PROD_RST;
		end else if (dp_wr_r) begin
			if (dp_addr_r == OFS_HDR)
				hdr_r <= hwdata;
			if (dp_addr_r == OFS_CERT)
				cert_r <= hwdata;
			if (dp_addr_r == OFS_PROD)
				prod_r <= hwdata;
		end
	end

	// a settings write and a clear cannot share a cycle on one bus, but
	// the set is given priority so a refusal is never lost
	// sticky refusal flag, write one to clear, set wins
	always_comb begin
		rej_nxt = rej_r;
		if (stat_wr && hwdata[STAT_REJ])
			rej_nxt = 1'b0;
		if (cfg_wr && !wr_legal)
			rej_nxt = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rej_r <= 1'b0;
		end else begin
			rej_r <= rej_nxt;
		end
	end

	// ****************************************
	// register reads
	// ****************************************
	// unmapped offsets read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (dp_addr_r)
			OFS_CFG: rd_mux = cfg_r;
			OFS_VDO: rd_mux = vdo_r;
			OFS_HDR: rd_mux = hdr_r;
			OFS_CERT: rd_mux = cert_r;
			OFS_PROD: rd_mux = prod_r;
			OFS_STAT: begin
				rd_mux[STAT_REJ] = rej_r;
				rd_mux[STAT_BUSY] = (state_r == PCV_SEND) || ack_valid_r;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// one wait state on reads, so a read right behind a
	// write sees the written value
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_r <= 1'b1;
			hrdata_r <= 32'h0000_0000;
		end else if (ap_take && !hwrite) begin
			hreadyout_r <= 1'b0;
		end else if (dp_rd_r && !hreadyout_r) begin
			hreadyout_r <= 1'b1;
			hrdata_r <= rd_mux;
		end
	end

	// ****************************************
	// identity answer sequencer
	// ****************************************
	// answer timing: request seen at an idle edge, first word one edge
	// later, four words on consecutive cycles; a request while busy is
	// dropped silently, the far port simply asks again
	// words are read live at each step, so a write to an identity word
	// during an answer shows up in the words not yet sent
	// header, certification, product, cable object
	always_comb begin
		unique case (idx_r)
			2'h0: word_sel = hdr_r;
			2'h1: word_sel = cert_r;
			2'h2: word_sel = prod_r;
			2'h3: word_sel = vdo_r;
		endcase
	end

	// next state; a request while sending is ignored
	always_comb begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		unique case (state_r)
			PCV_IDLE: begin
				idx_nxt = 2'h0;
				if (ack_req)
					state_nxt = PCV_SEND;
			end
			PCV_SEND: begin
				idx_nxt = idx_r + 2'h1;
				if (idx_r == ACK_LAST_IDX)
					state_nxt = PCV_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= PCV_IDLE;
			idx_r <= 2'h0;
		end else begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
		end
	end

	// one word per cycle, last on the cable object
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ack_valid_r <= 1'b0;
			ack_last_r <= 1'b0;
			ack_word_r <= 32'h0000_0000;
		end else begin
			ack_valid_r <= (state_r == PCV_SEND);
			ack_last_r <= (state_r == PCV_SEND) && (idx_r == ACK_LAST_IDX);
			if (state_r == PCV_SEND)
				ack_word_r <= word_sel;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// okay is the only response; kept in a flop like every other output
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp_r <= 1'b0;
		end else begin
			hresp_r <= 1'b0;
		end
	end

	assign hrdata = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp = hresp_r;
	assign ack_valid = ack_valid_r;
	assign ack_word = ack_word_r;
	assign ack_last = ack_last_r;
	assign cable_vdo = vdo_r;

endmodule

// file: src/pcv_vdo_pack.sv
module pcv_vdo_pack
	import pcv_pkg::*;
(
	// stored configuration or an incoming settings write
	input wire logic [31:0] cfg,
	// packed object and legality
	output logic [31:0] vdo,
	output logic legal
);

	// ****************************************
	// field packing
	// ****************************************
	// reserved bits stay at the zero default
	always_comb begin
		vdo = 32'h0000_0000;
		vdo[HW_LSB +: HW_W] = cfg[HW_LSB +: HW_W];
		vdo[FW_LSB +: FW_W] = cfg[FW_LSB +: FW_W];
		vdo[VER_LSB +: VER_W] = VER_1_0;
		vdo[PLUG_LSB +: PLUG_W] = cfg[PLUG_LSB +: PLUG_W];
		vdo[LAT_LSB +: LAT_W] = cfg[LAT_LSB +: LAT_W];
		vdo[TERM_LSB +: TERM_W] = cfg[TERM_LSB +: TERM_W];
		vdo[VMAX_LSB +: VMAX_W] = cfg[VMAX_LSB +: VMAX_W];
		vdo[CUR_LSB +: CUR_W] = cfg[CUR_LSB +: CUR_W];
		vdo[VTHRU_BIT] = cfg[VTHRU_BIT];
		vdo[SS_LSB +: SS_W] = cfg[SS_LSB +: SS_W];
		// bits 20, 17, 8:7, 3 never set above
	end

	// ****************************************
	// encoding check
	// ****************************************
	// reserved codes refused
	always_comb begin
		legal = 1'b1;
		if (!(cfg[PLUG_LSB +: PLUG_W] inside {PLUG_TYPEC, PLUG_CAPTIVE}))
			legal = 1'b0;
		if (cfg[LAT_LSB +: LAT_W] < LAT_MIN || cfg[LAT_LSB +: LAT_W] > LAT_MAX)
			legal = 1'b0;
		if (!(cfg[TERM_LSB +: TERM_W] inside {TERM_NONE, TERM_VCONN}))
			legal = 1'b0;
		if (!(cfg[CUR_LSB +: CUR_W] inside {CUR_3A, CUR_5A}))
			legal = 1'b0;
		if (cfg[SS_LSB +: SS_W] > SS_MAX)
			legal = 1'b0;
	end

endmodule

// file: tb/pcv_assertions.sv
module pcv_assertions
	import pcv_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// watched outputs
	input wire logic ack_valid,
	input wire logic ack_last,
	input wire logic [31:0] cable_vdo
);
	// ****
	// object and answer checks
	// ****
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// answer steps: three plain words, then the closing one
	sequence s_lead;
		(ack_valid && !ack_last) [*3];
	endsequence
	sequence s_end;
		ack_valid && ack_last;
	endsequence

	AST_VER: assert property (cable_vdo[23:21] == VER_1_0)
		else $error("object version not zero");
	AST_RSV: assert property ({cable_vdo[20], cable_vdo[17], cable_vdo[8:7], cable_vdo[3]} == 5'h00)
		else $error("reserved bit set");
	AST_PLUG: assert property (cable_vdo[19:18] == PLUG_TYPEC || cable_vdo[19:18] == PLUG_CAPTIVE)
		else $error("reserved plug code");
	AST_LAT: assert property (cable_vdo[16:13] >= LAT_MIN && cable_vdo[16:13] <= LAT_MAX)
		else $error("reserved latency code");
	AST_TERM: assert property (cable_vdo[12:11] == TERM_NONE || cable_vdo[12:11] == TERM_VCONN)
		else $error("reserved termination code");
	AST_CUR: assert property (cable_vdo[6:5] == CUR_3A || cable_vdo[6:5] == CUR_5A)
		else $error("reserved current code");
	AST_SS: assert property (cable_vdo[2:0] <= SS_MAX)
		else $error("reserved superspeed code");
	AST_BURST: assert property ($rose(ack_valid) |-> s_lead ##1 s_end)
		else $error("answer not four words");
	// closing word must follow three valid ones, never two closers in a row
	AST_LAST: assert property (ack_last |-> ack_valid && $past(ack_valid) && $past(ack_valid, 2)
		&& $past(ack_valid, 3) && !$past(ack_last))
		else $error("closing flag misplaced");
	COV_ANS: cover property (s_lead ##1 s_end);
endmodule

bind pcv_top pcv_assertions u_chk (
	.hclk(hclk),
	.hresetn(hresetn),
	.ack_valid(ack_valid),
	.ack_last(ack_last),
	.cable_vdo(cable_vdo)
);

// file: tb/pcv_reader.sv
module pcv_reader (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bench control
	input wire logic go,
	// answer from device
	input wire logic ack_valid,
	input wire logic [31:0] ack_word,
	input wire logic ack_last,
	// request and collected words
	output logic ack_req,
	output logic [3:0][31:0] words,
	output logic done
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// identity reader
	// ****
	logic [1:0] idx_r;
	// keep arrival order
	// request is go registered one edge later, so it lasts as long as go is held and a held level can start a second answer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ack_req <= 1'h0;
			idx_r <= 2'h0;
			done <= 1'h0;
			words <= '0;
		end else begin
			ack_req <= go;
			done <= ack_valid && ack_last;
			if (ack_valid) begin
				words[idx_r] <= ack_word;
				idx_r <= ack_last ? 2'h0 : idx_r + 2'h1;
			end
		end
	end
endmodule

// file: tb/tb_pcv_top.sv
module tb_pcv_top;
	import pcv_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// wiring
	// ****
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, go;
	logic ack_req, ack_valid, ack_last, rd_done;
	logic [31:0] haddr, hwdata, hrdata, ack_word, cable_vdo;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0][31:0] rd_w;
	int miscompares, cmp_count;
	assign hready = hreadyout;
	pcv_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ack_req(ack_req), .ack_valid(ack_valid),
		.ack_word(ack_word), .ack_last(ack_last), .cable_vdo(cable_vdo));
	pcv_reader u_rdr (.hclk(hclk), .hresetn(hresetn), .go(go), .ack_valid(ack_valid),
		.ack_word(ack_word), .ack_last(ack_last), .ack_req(ack_req), .words(rd_w), .done(rd_done));
	// ****
	// helpers
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// single ahb word transfer, held until hready is seen high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'h1;
		haddr <= {24'h00_0000, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'h1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'h0, a, 32'h0000_0000, q);
		chk(q, e);
		chk({31'h0000_0000, hresp}, 32'h0000_0000);
	endtask
	// legal object i of four; plug, termination, voltage, current and superspeed stepped through their legal codes
	function automatic logic [31:0] mk(input int i);
		logic [31:0] v;
		v = '0;
		v[31:28] = 4'(i + 9);
		v[27:24] = 4'(15 - i);
		v[19:18] = 2'(2 + i % 2);
		v[16:13] = (i == 0) ? 4'h1 : (i == 1) ? 4'h7 : (i == 2) ? 4'h8 : 4'hA;
		v[12:11] = 2'(i % 2);
		v[10:9] = 2'(i);
		v[6:5] = 2'(1 + i / 2);
		v[4] = 1'(i % 2);
		v[2:0] = 3'(i);
		return v;
	endfunction
	// ****
	// scenarios
	// ****
	task automatic t_reset;
		rd(OFS_CFG, CFG_RST);
		rd(OFS_VDO, CFG_RST);
		rd(OFS_HDR, HDR_RST);
		rd(8'h18, 32'h0000_0000);
		chk(cable_vdo, CFG_RST);
		$display("test reset done");
	endtask
	// junk in version and reserved bits must never reach the object
	task automatic t_fields;
		for (int i = 0; i < 4; i++) begin
			wr(OFS_CFG, mk(i) | 32'h00F2_0188);
			rd(OFS_VDO, mk(i));
			chk(cable_vdo, mk(i));
		end
		$display("test fields done");
	endtask
	task automatic t_refuse;
		logic [31:0] ms[11];
		logic [31:0] vs[11];
		ms = '{32'h000C_0000, 32'h000C_0000, 32'h0001_E000, 32'h0001_E000, 32'h0001_E000, 32'h0000_1800,
			32'h0000_1800, 32'h0000_0060, 32'h0000_0060, 32'h0000_0007, 32'h0000_0007};
		vs = '{32'h0000_0000, 32'h0004_0000, 32'h0000_0000, 32'h0001_6000, 32'h0001_E000, 32'h0000_1000,
			32'h0000_1800, 32'h0000_0000, 32'h0000_0060, 32'h0000_0004, 32'h0000_0007};
		for (int k = 0; k < 11; k++) begin
			wr(OFS_CFG, (mk(3) & ~ms[k]) | vs[k]);
			rd(OFS_CFG, mk(3));
			rd(OFS_STAT, 32'h0000_0001);
			wr(OFS_STAT, 32'h0000_0001);
			rd(OFS_STAT, 32'h0000_0000);
		end
		chk(cable_vdo, mk(3));
		$display("test refuse done");
	endtask
	// two answers in a row must carry the same four words in order
	task automatic t_ack;
		int n;
		wr(OFS_HDR, 32'h1111_2222);
		wr(OFS_CERT, 32'h3333_4444);
		wr(OFS_PROD, 32'h5555_6666);
		repeat (2) begin
			go <= 1'h1;
			@(posedge hclk);
			go <= 1'h0;
			// busy seen once the request is taken, a cycle before the first word goes out
			rd(OFS_STAT, 32'h0000_0002);
			n = 0;
			do begin
				@(posedge hclk);
				n++;
			end while (rd_done !== 1'b1 && n < 20);
			chk(rd_w[0], 32'h1111_2222);
			chk(rd_w[1], 32'h3333_4444);
			chk(rd_w[2], 32'h5555_6666);
			chk(rd_w[3], mk(3));
			// last word then the reader's done flop: seen four edges after the status read
			chk(32'(n), 32'h0000_0004);
			rd(OFS_STAT, 32'h0000_0000);
		end
		$display("test answer done");
	endtask
	// reset in mid-run brings settings and outputs back to reset values
	task automatic t_rereset;
		hresetn <= 1'h0;
		repeat (2) @(posedge hclk);
		chk(hrdata, 32'h0000_0000);
		hresetn <= 1'h1;
		chk(cable_vdo, CFG_RST);
		rd(OFS_CFG, CFG_RST);
		rd(OFS_HDR, HDR_RST);
		$display("test reset again done");
	endtask
	task automatic conclude;
		$display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ****
	// run
	// ****
	initial begin
		hclk = 1'h0;
		forever #2 hclk = ~hclk;
	end
	// watchdog well beyond the few hundred cycles needed
	initial begin
		#40000;
		miscompares++;
		conclude;
	end
	initial begin
		hsel = 1'h0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		go = 1'h0;
		hresetn = 1'h0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'h1;
		t_reset;
		t_fields;
		t_refuse;
		t_ack;
		t_rereset;
		conclude;
	end
endmodule
